// ==== rtl/tec_pkg.sv ====
// package for the two-channel event totalizer
// assumes one 200 MHz measurement clock and an APB register port
package tec_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_START_DLY = 8'h08;
  localparam logic [7:0] OFF_STOP_DLY = 8'h0c;
  localparam logic [7:0] OFF_BLOCK = 8'h10;
  localparam logic [7:0] OFF_PACING = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_COUNT_A = 8'h1c;
  localparam logic [7:0] OFF_COUNT_B = 8'h20;
  localparam logic [7:0] OFF_MAIN = 8'h24;
  localparam logic [7:0] OFF_DIFF = 8'h28;
  localparam logic [7:0] OFF_RATIO = 8'h2c;
  localparam logic [7:0] OFF_RESULT = 8'h30;
  localparam logic [7:0] OFF_SAMPLES = 8'h34;
  // command bits
  localparam int CMD_RUN_HOLD = 0;
  localparam int CMD_RESTART = 1;
  // status bits
  localparam int STS_GATE = 0;
  localparam int STS_RUN = 1;
  localparam int STS_RESULT = 2;
  localparam int STS_BLOCK = 3;
  // totalize modes
  localparam logic [2:0] MODE_A = 3'h0;
  localparam logic [2:0] MODE_B = 3'h1;
  localparam logic [2:0] MODE_SUM = 3'h2;
  localparam logic [2:0] MODE_DIFF = 3'h3;
  localparam logic [2:0] MODE_RATIO = 3'h4;
  // arming channels
  localparam logic [1:0] CH_A = 2'h0;
  localparam logic [1:0] CH_B = 2'h1;
  localparam logic [1:0] CH_E = 2'h2;
  localparam logic [1:0] CH_TIME = 2'h3;
  // reset values
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_DLY = 32'h0000_0002;
  localparam logic [31:0] RST_BLOCK = 32'h0000_0001;
  localparam logic [31:0] RST_PACING = 32'h0000_0002;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int DLY_MIN_NS = 10;
  localparam longint DLY_MAX_S = 2;
  localparam logic [31:0] DLY_MIN_CYC =
    32'((DLY_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [31:0] DLY_MAX_CYC =
    32'(DLY_MAX_S * CLK_MHZ * 64'd1000000);
  // ratio fraction bits
  localparam int RATIO_FRAC = 16;

  typedef struct packed {
    logic [20:0] unused;
    logic stop_slope;
    logic [1:0] stop_ch;
    logic start_slope;
    logic [1:0] start_ch;
    logic arm_block;
    logic armed;
    logic [2:0] mode;
  } tec_ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } tec_edge_t;
endpackage : tec_pkg

// ==== rtl/tec_edge_sync.sv ====
// two-flop synchroniser with single-pulse edge detection
// assumes an asynchronous comparator output on din
`timescale 1ns/1ps
module tec_edge_sync
  import tec_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic din,
  output tec_edge_t edge_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign edge_o.rise = s2 & ~s3;
  assign edge_o.fall = ~s2 & s3;
endmodule : tec_edge_sync

// ==== rtl/tec_ratio_div.sv ====
// sequential unsigned divider giving a fixed-point quotient
// assumes operands hold steady only at start; start ignored while busy
`timescale 1ns/1ps
module tec_ratio_div
  import tec_pkg::*;
#(
  parameter int W = 32,
  parameter int F = RATIO_FRAC
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic busy,
  output logic [W-1:0] quot
);
  localparam int N = W + F;
  logic [N-1:0] dvd;
  logic [N-1:0] q;
  logic [W:0] rem;
  logic [W-1:0] dsr;
  logic [7:0] cnt;
  logic [W:0] trial;

  assign trial = {rem[W-1:0], dvd[N-1]} - {1'b0, dsr};

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      busy <= 1'b0;
      cnt <= 8'h00;
      dvd <= '0;
      q <= '0;
      rem <= '0;
      dsr <= '0;
      quot <= '0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      cnt <= 8'(N);
      dvd <= {num, {F{1'b0}}};
      dsr <= den;
      rem <= '0;
      q <= '0;
    end
    else if (busy)
    begin
      dvd <= {dvd[N-2:0], 1'b0};
      if (!trial[W])
      begin
        rem <= trial;
        q <= {q[N-2:0], 1'b1};
      end
      else
      begin
        rem <= {rem[W-1:0], dvd[N-1]};
        q <= {q[N-2:0], 1'b0};
      end
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01)
      begin
        busy <= 1'b0;
        if (dsr == '0)
          quot <= '1;
        else if (!trial[W])
          quot <= W'({q[N-2:0], 1'b1});
        else
          quot <= W'({q[N-2:0], 1'b0});
      end
    end
  end
endmodule : tec_ratio_div

// ==== rtl/tec_totalize.sv ====
// two-channel event totalizer with manual and armed gating
// assumes comparator outputs on trig_a, trig_b, ext_gate, APB master
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// Overview of operation
// - mode A counts A, offers A-B, A/B
// - mode B counts B, offers A-B, A/B
// - sum mode reports A+B, aux A and B
// - difference mode reports A-B, aux A, B
// - ratio mode reports A/B, aux A, B
// - counts readable live while gate open
// - counts accumulate until restart command
// - run/hold toggles gate; restart zeroes counts
// - manual: no block/pacing; levels computed once
// - armed gate from channel A, B or E
// - armed: block, pacing; result per stop
// - arm each sample or each block
// - start delay 10 ns to 2 s
// - stop hold-off 10 ns to 2 s
// - start and stop slopes independent
// - time stop closes gate after measurement time
module tec_totalize
  import tec_pkg::*;
#(
  parameter logic [31:0] MAX_DELAY_CYC = DLY_MAX_CYC,
  parameter int CW = 32
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic ext_gate,
  output logic gate_open,
  output logic level_calc_req,
  output logic result_strobe
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_START, ST_START_DLY, ST_HOLDOFF, ST_WAIT_STOP,
    ST_PACE
  } tec_state_t;

  tec_state_t state;
  tec_state_t next_state;
  tec_ctrl_t ctrl;
  logic [31:0] start_dly;
  logic [31:0] stop_dly;
  logic [31:0] block_size;
  logic [31:0] pacing;
  logic [CW-1:0] cnt_a;
  logic [CW-1:0] cnt_b;
  logic [31:0] result;
  logic [31:0] samples;
  logic [31:0] tmr;
  logic run;
  logic result_valid;
  logic block_done;
  logic lvl_done;
  logic [31:0] rdata;
  logic slverr_q;
  tec_edge_t edges [3];
  logic [2:0] pins;

  // synchronised inputs
  assign pins = {ext_gate, trig_b, trig_a};
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      tec_edge_sync u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .din(pins[g]),
        .edge_o(edges[g])
      );
    end
  endgenerate

  // bus decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire wr_ctrl = wr & (paddr == OFF_CTRL);
  wire wr_cmd = wr & (paddr == OFF_CMD);
  wire wr_sdly = wr & (paddr == OFF_START_DLY);
  wire wr_pdly = wr & (paddr == OFF_STOP_DLY);
  wire wr_blk = wr & (paddr == OFF_BLOCK);
  wire wr_pace = wr & (paddr == OFF_PACING);
  wire rd_result = rd & (paddr == OFF_RESULT);
  wire rd_status = rd & (paddr == OFF_STATUS);
  wire cmd_toggle = wr_cmd & pwdata[CMD_RUN_HOLD];
  wire cmd_restart = wr_cmd & pwdata[CMD_RESTART];

  // derived results
  wire [CW-1:0] sum_ab = cnt_a + cnt_b;
  wire [CW-1:0] diff_ab = cnt_a - cnt_b;
  wire div_busy;
  wire [CW-1:0] ratio_ab;
  tec_ratio_div #(.W(CW), .F(RATIO_FRAC)) u_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(1'b1),
    .num(cnt_a),
    .den(cnt_b),
    .busy(div_busy),
    .quot(ratio_ab)
  );
  wire [CW-1:0] main_val =
    (ctrl.mode == MODE_B) ? cnt_b :
    (ctrl.mode == MODE_SUM) ? sum_ab :
    (ctrl.mode == MODE_DIFF) ? diff_ab :
    (ctrl.mode == MODE_RATIO) ? ratio_ab : cnt_a;

  // arming edge selection
  wire [2:0] rise_v = {edges[2].rise, edges[1].rise, edges[0].rise};
  wire [2:0] fall_v = {edges[2].fall, edges[1].fall, edges[0].fall};
  wire start_ev = (ctrl.start_ch != CH_TIME) &&
    (ctrl.start_slope ? fall_v[ctrl.start_ch] : rise_v[ctrl.start_ch]);
  wire stop_ev = (ctrl.stop_ch != CH_TIME) &&
    (ctrl.stop_slope ? fall_v[ctrl.stop_ch] : rise_v[ctrl.stop_ch]);

  // delay clamps
  function automatic logic [31:0] clamp_dly(input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (r < DLY_MIN_CYC)
      r = DLY_MIN_CYC;
    if (r > MAX_DELAY_CYC)
      r = MAX_DELAY_CYC;
    return r;
  endfunction : clamp_dly

  wire tmr_done = (tmr <= 32'h0000_0001);
  wire armed_run = ctrl.armed & run;
  wire stop_time = (ctrl.stop_ch == CH_TIME);
  wire last_sample = (samples + 32'h0000_0001 >= block_size);
  wire gate_armed = (state == ST_HOLDOFF) || (state == ST_WAIT_STOP);
  wire stop_hit = ((state == ST_HOLDOFF) && tmr_done && stop_time) ||
    ((state == ST_WAIT_STOP) && stop_ev);
  wire next_gate = ctrl.armed ? gate_armed : run;

  // armed sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (armed_run)
          next_state = ST_WAIT_START;
      ST_WAIT_START:
        if (start_ev)
          next_state = ST_START_DLY;
      ST_START_DLY:
        if (tmr_done)
          next_state = ST_HOLDOFF;
      ST_HOLDOFF:
        if (tmr_done)
          next_state = stop_time ? ST_PACE : ST_WAIT_STOP;
      ST_WAIT_STOP:
        if (stop_ev)
          next_state = ST_PACE;
      ST_PACE:
        if (tmr_done)
          next_state = (ctrl.arm_block && samples != 32'h0) ?
            ST_START_DLY : ST_WAIT_START;
    endcase
    if (!armed_run)
      next_state = ST_IDLE;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // delay timer
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      tmr <= 32'h0;
    else if (state == ST_WAIT_START || (state == ST_PACE && tmr_done &&
      next_state == ST_START_DLY))
      tmr <= clamp_dly(start_dly);
    else if (state == ST_START_DLY && tmr_done)
      tmr <= clamp_dly(stop_dly);
    else if (stop_hit)
      tmr <= clamp_dly(pacing);
    else if (!tmr_done)
      tmr <= tmr - 32'h0000_0001;
  end

  // control registers
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ctrl <= RST_CTRL;
      start_dly <= RST_DLY;
      stop_dly <= RST_DLY;
      block_size <= RST_BLOCK;
      pacing <= RST_PACING;
      run <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= pwdata;
      if (wr_sdly)
        start_dly <= pwdata;
      if (wr_pdly)
        stop_dly <= pwdata;
      if (wr_blk)
        block_size <= pwdata;
      if (wr_pace)
        pacing <= pwdata;
      if (cmd_toggle)
        run <= ~run;
    end
  end

  // accumulators, live and never cleared by gate
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || cmd_restart)
    begin
      cnt_a <= '0;
      cnt_b <= '0;
    end
    else if (gate_open)
    begin
      if (edges[0].rise)
        cnt_a <= cnt_a + 1'b1;
      if (edges[1].rise)
        cnt_b <= cnt_b + 1'b1;
    end
  end

  // per-stop results and block statistics
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      gate_open <= 1'b0;
      result <= 32'h0;
      samples <= 32'h0;
      result_valid <= 1'b0;
      block_done <= 1'b0;
      result_strobe <= 1'b0;
    end
    else
    begin
      gate_open <= next_gate;
      result_strobe <= stop_hit;
      if (stop_hit)
      begin
        result <= 32'(main_val);
        samples <= last_sample ? 32'h0 : samples + 32'h0000_0001;
      end
      else if (cmd_restart || !ctrl.armed)
        samples <= 32'h0;
      if (stop_hit)
        result_valid <= 1'b1;
      else if (rd_result || cmd_restart)
        result_valid <= 1'b0;
      if (stop_hit && last_sample)
        block_done <= 1'b1;
      else if (rd_status || cmd_restart)
        block_done <= 1'b0;
    end
  end

  // one level computation before a manual run starts
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      level_calc_req <= 1'b0;
      lvl_done <= 1'b0;
    end
    else
    begin
      level_calc_req <= cmd_toggle & ~run & ~ctrl.armed & ~lvl_done;
      if (cmd_restart)
        lvl_done <= 1'b0;
      else if (cmd_toggle && !run && !ctrl.armed)
        lvl_done <= 1'b1;
    end
  end

  // read mux
  always_comb
  begin
    rdata = 32'h0;
    unique case (paddr)
      OFF_CTRL: rdata = ctrl;
      OFF_START_DLY: rdata = start_dly;
      OFF_STOP_DLY: rdata = stop_dly;
      OFF_BLOCK: rdata = block_size;
      OFF_PACING: rdata = pacing;
      OFF_STATUS: rdata = {28'h0, block_done, result_valid, run, gate_open};
      OFF_COUNT_A: rdata = 32'(cnt_a);
      OFF_COUNT_B: rdata = 32'(cnt_b);
      OFF_MAIN: rdata = 32'(main_val);
      OFF_DIFF: rdata = 32'(diff_ab);
      OFF_RATIO: rdata = 32'(ratio_ab);
      OFF_RESULT: rdata = result;
      OFF_SAMPLES: rdata = samples;
      default: rdata = 32'h0;
    endcase
  end

  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_SAMPLES);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h0;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0 : rdata;
      slverr_q <= ~mapped;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access & slverr_q;
endmodule : tec_totalize

// ==== tb/tec_totalize_chk.sv ====
// port checker for the event totalizer
// assumes a bind onto tec_totalize
`timescale 1ns/1ps
module tec_totalize_chk
  import tec_pkg::*;
#(
  parameter logic [31:0] MAX_DELAY_CYC = DLY_MAX_CYC
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trig_a,
  input wire logic trig_b,
  input wire logic ext_gate,
  input wire logic gate_open,
  input wire logic level_calc_req,
  input wire logic result_strobe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  logic armed;
  logic timed;
  logic [31:0] stop_dly;
  logic [31:0] gate_cnt;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire bad = (paddr > OFF_SAMPLES) || (paddr[1:0] != 2'h0);
  wire tec_ctrl_t wctl = pwdata;
  wire run_cmd = wr && paddr == OFF_CMD && pwdata[CMD_RUN_HOLD]
    && !pwdata[CMD_RESTART];
  wire [31:0] stop_exp = (stop_dly < DLY_MIN_CYC) ? DLY_MIN_CYC :
    ((stop_dly > MAX_DELAY_CYC) ? MAX_DELAY_CYC : stop_dly);

  // mirror of the settings the checks depend on
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      armed <= 1'b0;
      timed <= 1'b0;
      stop_dly <= RST_DLY;
      gate_cnt <= 32'h0;
    end
    else
    begin
      if (wr && paddr == OFF_CTRL)
      begin
        armed <= wctl.armed;
        timed <= wctl.stop_ch == CH_TIME;
      end
      if (wr && paddr == OFF_STOP_DLY)
      begin
        stop_dly <= pwdata;
      end
      gate_cnt <= gate_open ? gate_cnt + 32'h1 : 32'h0;
    end
  end

  AST_PREADY_NOW: assert property (acc |-> pready)
    else $error("access cycle without pready");
  AST_ERR_UNMAPPED: assert property (
    acc && bad |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_OK_MAPPED: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access refused");
  AST_LEVEL_ONCE: assert property (
    level_calc_req |=> !level_calc_req)
    else $error("level request longer than one cycle");
  AST_LEVEL_MANUAL: assert property (
    level_calc_req |-> !armed)
    else $error("level request in armed operation");
  AST_RESULT_ONCE: assert property (
    result_strobe |=> !result_strobe)
    else $error("result strobe longer than one cycle");
  AST_RESULT_ARMED: assert property (
    result_strobe |-> armed)
    else $error("result strobe in manual operation");
  AST_MAN_OPEN: assert property (
    $rose(gate_open) && !armed |-> $past(run_cmd) || $past(run_cmd, 2))
    else $error("manual gate opened without toggle");
  AST_MAN_CLOSE: assert property (
    $fell(gate_open) && !armed |-> $past(run_cmd) || $past(run_cmd, 2))
    else $error("manual gate closed without toggle");
  AST_TIMED_LEN: assert property (
    $fell(gate_open) && armed && timed
    |-> gate_cnt + 32'h1 >= stop_exp && gate_cnt <= stop_exp + 32'h1)
    else $error("timed gate length wrong");
  AST_STOP_RESULT: assert property (
    $fell(gate_open) && armed |-> $past(result_strobe))
    else $error("armed stop gave no result");

  COV_MAN_RUN: cover property ($rose(gate_open) && !armed);
  COV_TIMED: cover property ($fell(gate_open) && timed);
  COV_REFUSED: cover property (acc && pslverr);
  COV_ARMED_RESULT: cover property (result_strobe && armed);
endmodule : tec_totalize_chk

// ==== tb/tec_src_model.sv ====
// signal sources standing on inputs A, B and E
// assumes tasks are called just after a rising clock edge
`timescale 1ns/1ps
module tec_src_model
(
  input wire logic sys_clk,
  output logic trig_a,
  output logic trig_b,
  output logic ext_gate
);
  initial
  begin
    trig_a = 1'b0;
    trig_b = 1'b0;
    ext_gate = 1'b0;
  end

  // one pin level, changed right after the next edge
  task automatic drive(input int ch, input logic v);
    @(posedge sys_clk);
    case (ch)
      0: trig_a <= v;
      1: trig_b <= v;
      default: ext_gate <= v;
    endcase
  endtask : drive

  // n events, each level held two clocks
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      drive(ch, 1'b1);
      @(posedge sys_clk);
      drive(ch, 1'b0);
      @(posedge sys_clk);
    end
  endtask : pulse
endmodule : tec_src_model

// ==== tb/test_tec_totalize.sv ====
// self-checking bench for the event totalizer
// assumes tec_src_model on the trigger pins, APB master here
`timescale 1ns/1ps
module test_tec_totalize
  import tec_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, a, b, q;
  logic pready, pslverr, trig_a, trig_b, ext_gate;
  logic gate_open, level_calc_req, result_strobe;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 82;
  int cycles = 0;
  int na, nb;
  int n_lvl = 0;
  logic [32:0] exp_q[$];
  string name_q[$];

  always #2.5 sys_clk = ~sys_clk;

  tec_totalize #(.MAX_DELAY_CYC(32'd64)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_a(trig_a), .trig_b(trig_b),
    .ext_gate(ext_gate), .gate_open(gate_open),
    .level_calc_req(level_calc_req), .result_strobe(result_strobe));
  tec_src_model i_src (.sys_clk(sys_clk), .trig_a(trig_a),
    .trig_b(trig_b), .ext_gate(ext_gate));

  task automatic chk(input string n, input logic [32:0] seen,
    input logic [32:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
      @(posedge sys_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic rd(input logic [7:0] ad, input logic [31:0] e,
    input logic err);
    exp_q.push_back({err, e});
    name_q.push_back($sformatf("read %h", ad));
    apb(1'b0, ad, 32'h0);
  endtask : rd

  task automatic wait_res();
    int t;
    t = 0;
    while (result_strobe !== 1'b1 && t < 300)
    begin
      t++;
      @(posedge sys_clk);
    end
    chk("result strobe", 33'(t < 300), 33'h1);
  endtask : wait_res

  // read results checked against notes, plus the run limit
  always @(posedge sys_clk)
  begin
    cycles++;
    if (level_calc_req === 1'b1)
      n_lvl++;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk(name_q.pop_front(), {pslverr, prdata}, exp_q.pop_front());
    if (cycles == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(OFF_CTRL, RST_CTRL, 1'b0);
    rd(OFF_START_DLY, RST_DLY, 1'b0);
    rd(OFF_STOP_DLY, RST_DLY, 1'b0);
    rd(OFF_BLOCK, RST_BLOCK, 1'b0);
    rd(OFF_PACING, RST_PACING, 1'b0);
    rd(OFF_CMD, 32'h0, 1'b0);
    rd(8'h38, 32'h0, 1'b1);
    rd(8'h06, 32'h0, 1'b1);
    for (int m = 0; m < 5; m++)
    begin
      na = 1 + ($unsigned($random(seed)) % 5);
      nb = 2 + ($unsigned($random(seed)) % 4);
      apb(1'b1, OFF_CTRL, 32'(m));
      apb(1'b1, OFF_CMD, 32'h2);
      apb(1'b1, OFF_CMD, 32'h1);
      i_src.pulse(0, na);
      repeat (6) @(posedge sys_clk);
      rd(OFF_COUNT_A, 32'(na), 1'b0);
      i_src.pulse(1, nb);
      repeat (6) @(posedge sys_clk);
      apb(1'b1, OFF_CMD, 32'h1);
      i_src.pulse(0, 2);
      i_src.pulse(1, 2);
      apb(1'b1, OFF_CMD, 32'h1);
      i_src.pulse(0, na);
      i_src.pulse(1, nb);
      repeat (6) @(posedge sys_clk);
      apb(1'b1, OFF_CMD, 32'h1);
      repeat (100) @(posedge sys_clk);
      a = 32'(2 * na);
      b = 32'(2 * nb);
      q = (a << 16) / b;
      rd(OFF_COUNT_A, a, 1'b0);
      rd(OFF_COUNT_B, b, 1'b0);
      rd(OFF_DIFF, a - b, 1'b0);
      rd(OFF_RATIO, q, 1'b0);
      rd(OFF_MAIN, m == 0 ? a : m == 1 ? b : m == 2 ? a + b :
        m == 3 ? a - b : q, 1'b0);
      apb(1'b1, OFF_CMD, 32'h2);
      rd(OFF_COUNT_B, 32'h0, 1'b0);
    end
    // armed by E: rising start, falling stop, bounce in hold-off
    apb(1'b1, OFF_CTRL, 32'h648);
    apb(1'b1, OFF_START_DLY, 32'd40);
    apb(1'b1, OFF_STOP_DLY, 32'd20);
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b1, OFF_CMD, 32'h1);
    i_src.drive(2, 1'b1);
    repeat (35) @(posedge sys_clk);
    chk("gate early", 33'(gate_open), 33'h0);
    repeat (15) @(posedge sys_clk);
    chk("gate open", 33'(gate_open), 33'h1);
    i_src.drive(2, 1'b0);
    @(posedge sys_clk);
    i_src.drive(2, 1'b1);
    repeat (25) @(posedge sys_clk);
    chk("hold-off", 33'(gate_open), 33'h1);
    i_src.pulse(0, 3);
    repeat (6) @(posedge sys_clk);
    i_src.drive(2, 1'b0);
    wait_res();
    repeat (3) @(posedge sys_clk);
    chk("gate shut", 33'(gate_open), 33'h0);
    rd(OFF_STATUS, 32'h0000_000e, 1'b0);
    rd(OFF_RESULT, 32'd3, 1'b0);
    rd(OFF_STATUS, 32'h0000_0002, 1'b0);
    apb(1'b1, OFF_CMD, 32'h1);
    // armed by A with a timed stop
    apb(1'b1, OFF_CTRL, 32'h309);
    apb(1'b1, OFF_START_DLY, 32'd2);
    apb(1'b1, OFF_STOP_DLY, 32'd30);
    apb(1'b1, OFF_CMD, 32'h2);
    apb(1'b1, OFF_CMD, 32'h1);
    i_src.pulse(0, 1);
    repeat (8) @(posedge sys_clk);
    i_src.pulse(1, 3);
    wait_res();
    repeat (3) @(posedge sys_clk);
    rd(OFF_RESULT, 32'd3, 1'b0);
    rd(OFF_COUNT_A, 32'd0, 1'b0);
    chk("level requests", 33'(n_lvl), 33'h5);
    end_of_test();
  end
endmodule : test_tec_totalize

bind tec_totalize tec_totalize_chk #(.MAX_DELAY_CYC(MAX_DELAY_CYC)) i_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trig_a(trig_a), .trig_b(trig_b),
  .ext_gate(ext_gate), .gate_open(gate_open),
  .level_calc_req(level_calc_req), .result_strobe(result_strobe));
